/* File: src/acr_core.sv */
// calibration, frame check words, map check and reset sequencing
//
// The strobed register port and the address map were left to the implementer.
module acr_core #(
  parameter int unsigned POR_CYCLES = acr_pkg::POWER_ON_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  input wire logic sync_reset_n,
  input wire logic raw_valid,
  input wire logic [23:0] raw_ch0,
  input wire logic [23:0] raw_ch1,
  output logic data_ready_n
);
  typedef struct packed {
    acr_pkg::acr_phase_e phase;
    logic [23:0] cnt;
    logic [15:0] low_cnt;
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] mosi_s;
    logic [1:0] pin_s;
    logic [16:0][15:0] regs;
    logic check_err;
    logic map_chg;
    logic [15:0] map_crc;
    logic [15:0] map_val;
    logic [8:0] map_idx;
    logic in_frame;
    logic [6:0] bit_cnt;
    logic [71:0] tx_sh;
    logic [71:0] rx_sh;
    logic [15:0] tx_crc;
    logic [15:0] rx_crc;
    logic [15:0] rx_chk;
    logic ack;
    logic [15:0] ack_word;
    logic [23:0] ch0;
    logic [23:0] ch1;
    logic data_ready_n_n;
    logic miso;
    logic [15:0] rdata;
  } acr_state_s;

  acr_state_s s_q;
  acr_state_s s_d;

  // one serial bit into a check register
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic b,
                                           input logic ansi);
    logic [15:0] poly;
    poly = ansi ? acr_pkg::POLY_ANSI : acr_pkg::POLY_CCITT;
    crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? poly : 16'h0000);
  endfunction

  // offset, gain and saturation of one result
  function automatic logic [23:0] correct(input logic [23:0] raw,
                                          input logic [23:0] off,
                                          input logic [23:0] gain);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [26:0] sh;
    diff = $signed({raw[23], raw}) - $signed({off[23], off});
    prod = diff * $signed({1'b0, gain});
    sh = prod[49:23];
    if (sh > 27'sh07FFFFF) begin
      correct = 24'h7FFFFF;
    end else if (sh < -27'sh0800000) begin
      correct = 24'h800000;
    end else begin
      correct = sh[23:0];
    end
  endfunction

  // hi word plus top byte of lo word form a coefficient
  function automatic logic [23:0] coef(input logic [15:0] hi,
                                       input logic [15:0] lo);
    coef = {hi, lo[15:8]};
  endfunction

  // index of a mapped register within the array
  function automatic logic [4:0] idx(input logic [5:0] a);
    idx = 5'(a - acr_pkg::A_MAP_FIRST);
  endfunction

  // true for the writable, check-covered registers
  function automatic logic in_map(input logic [5:0] a);
    in_map = (a >= acr_pkg::A_MAP_FIRST) && (a <= acr_pkg::A_MAP_LAST);
  endfunction

  // combinational views, strobes and edge marks
  logic [15:0] mode;
  logic ansi;
  logic [15:0] status;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic ready;
  logic [15:0] cmd;
  logic chk_ok;
  logic soft_rst;
  logic [15:0] map_next;
  logic [15:0] word0;
  logic map_set;

  // decoded views of the state
  always_comb begin
    mode = s_q.regs[idx(acr_pkg::A_MODE)];
    ansi = mode[acr_pkg::MODE_ANSI];
    status = 16'h0000;
    status[acr_pkg::STAT_CHECK_ERR] = s_q.check_err;
    status[acr_pkg::STAT_MAP_CHG] = s_q.map_chg;
    sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_s[2];
    sclk_fall = ~s_q.sclk_s[1] & s_q.sclk_s[2];
    cs_fall = ~s_q.cs_s[1] & s_q.cs_s[2];
    cs_rise = s_q.cs_s[1] & ~s_q.cs_s[2];
    ready = (s_q.phase == acr_pkg::ACR_RUN);
    cmd = s_q.rx_sh[71:56];
    chk_ok = ~mode[acr_pkg::MODE_RX_CHECK] ||
             (s_q.rx_crc == s_q.rx_chk);
    map_next = crc_step(s_q.map_crc,
                        s_q.regs[s_q.map_idx[8:4]][~s_q.map_idx[3:0]],
                        ansi);
    word0 = s_q.ack ? s_q.ack_word : status;
  end

  // next state
  always_comb begin
    s_d = s_q;
    soft_rst = 1'b0;
    map_set = 1'b0;
    s_d.sclk_s = {s_q.sclk_s[1:0], sclk};
    s_d.cs_s = {s_q.cs_s[1:0], cs_n};
    s_d.mosi_s = {s_q.mosi_s[0], mosi};
    s_d.pin_s = {s_q.pin_s[0], sync_reset_n};

    // register port
    if (reg_rd) begin
      case (reg_addr)
        acr_pkg::A_STATUS: begin
          s_d.rdata = status;
          s_d.map_chg = 1'b0;
          s_d.check_err = 1'b0;
        end
        acr_pkg::A_MAP_CHECK: s_d.rdata = s_q.map_val;
        default: s_d.rdata = in_map(reg_addr) ?
                             s_q.regs[idx(reg_addr)] : 16'h0000;
      endcase
    end
    if (reg_wr && in_map(reg_addr)) begin
      s_d.regs[idx(reg_addr)] = reg_wdata;
    end

    // continuous map check
    if (mode[acr_pkg::MODE_MAP_CHECK]) begin
      if (s_q.map_idx == acr_pkg::MAP_LAST_BIT) begin
        s_d.map_val = map_next;
        if (map_next != s_q.map_val) begin
          s_d.map_chg = 1'b1;
          map_set = 1'b1;
        end
        s_d.map_crc = acr_pkg::CRC_SEED;
        s_d.map_idx = 9'h000;
      end else begin
        s_d.map_crc = map_next;
        s_d.map_idx = 9'(s_q.map_idx + 9'h001);
      end
    end else begin
      s_d.map_crc = acr_pkg::CRC_SEED;
      s_d.map_idx = 9'h000;
    end

    // new conversion results
    if (raw_valid && s_q.phase != acr_pkg::ACR_POR &&
        s_q.phase != acr_pkg::ACR_HOLD) begin
      s_d.ch0 = correct(raw_ch0,
                  coef(s_q.regs[idx(acr_pkg::A_OFF0_HI)],
                       s_q.regs[idx(acr_pkg::A_OFF0_LO)]),
                  coef(s_q.regs[idx(acr_pkg::A_GAIN0_HI)],
                       s_q.regs[idx(acr_pkg::A_GAIN0_LO)]));
      s_d.ch1 = correct(raw_ch1,
                  coef(s_q.regs[idx(acr_pkg::A_OFF1_HI)],
                       s_q.regs[idx(acr_pkg::A_OFF1_LO)]),
                  coef(s_q.regs[idx(acr_pkg::A_GAIN1_HI)],
                       s_q.regs[idx(acr_pkg::A_GAIN1_LO)]));
      if (ready) begin
        s_d.data_ready_n_n = 1'b0;
      end
    end

    // serial frame handling, only once ready
    if (ready && cs_fall) begin
      s_d.in_frame = 1'b1;
      s_d.bit_cnt = 7'h00;
      s_d.tx_sh = {word0, 8'h00, s_q.ch0, s_q.ch1};
      s_d.tx_crc = acr_pkg::CRC_SEED;
      s_d.rx_crc = acr_pkg::CRC_SEED;
      s_d.data_ready_n_n = 1'b1;
      s_d.ack = 1'b0;
      // status goes out now; a map change flagged this cycle survives
      if (!s_q.ack) begin
        s_d.check_err = 1'b0;
        s_d.map_chg = map_set;
      end
    end
    if (s_q.in_frame && sclk_rise) begin
      if (s_q.bit_cnt < acr_pkg::PAYLOAD_BITS) begin
        s_d.miso = s_q.tx_sh[71];
        s_d.tx_sh = {s_q.tx_sh[70:0], 1'b0};
        s_d.tx_crc = crc_step(s_q.tx_crc, s_q.tx_sh[71], ansi);
      end else if (s_q.bit_cnt < acr_pkg::CHECK_END) begin
        s_d.miso = s_q.tx_crc[15];
        s_d.tx_crc = {s_q.tx_crc[14:0], 1'b0};
      end else begin
        s_d.miso = 1'b0;
      end
    end
    if (s_q.in_frame && sclk_fall &&
        s_q.bit_cnt < acr_pkg::FRAME_BITS) begin
      s_d.bit_cnt = 7'(s_q.bit_cnt + 7'h01);
      if (s_q.bit_cnt < acr_pkg::PAYLOAD_BITS) begin
        s_d.rx_sh = {s_q.rx_sh[70:0], s_q.mosi_s[1]};
        s_d.rx_crc = crc_step(s_q.rx_crc, s_q.mosi_s[1], ansi);
      end else if (s_q.bit_cnt < acr_pkg::CHECK_END) begin
        s_d.rx_chk = {s_q.rx_chk[14:0], s_q.mosi_s[1]};
      end
    end
    if (s_q.in_frame && cs_rise) begin
      s_d.in_frame = 1'b0;
      s_d.miso = 1'b0;
      if (s_q.bit_cnt == acr_pkg::FRAME_BITS) begin
        if (!chk_ok) begin
          s_d.check_err = 1'b1;
        end
        if (cmd[15:13] == acr_pkg::CMD_WRITE_TOP) begin
          if (in_map(cmd[12:7])) begin
            s_d.regs[idx(cmd[12:7])] = s_q.rx_sh[47:32];
          end
          s_d.ack = chk_ok;
          s_d.ack_word = {acr_pkg::ACK_WRITE_TOP, cmd[12:0]};
        end else if (chk_ok && cmd == acr_pkg::CMD_RESET) begin
          soft_rst = 1'b1;
        end
      end
    end

    // reset sequencing
    // pin held low past the minimum width forces reset
    if (!s_q.pin_s[1] && s_q.phase != acr_pkg::ACR_POR) begin
      if (s_q.low_cnt != 16'(acr_pkg::RESET_LOW_CYCLES)) begin
        s_d.low_cnt = 16'(s_q.low_cnt + 16'h0001);
      end else begin
        soft_rst = 1'b1;
      end
    end else begin
      s_d.low_cnt = 16'h0000;
    end
    // power-on, hold and acquire phases keep data-ready low
    case (s_q.phase)
      acr_pkg::ACR_POR: begin
        s_d.data_ready_n_n = 1'b0;
        s_d.cnt = 24'(s_q.cnt + 24'h000001);
        if (s_q.cnt == 24'(POR_CYCLES - 1)) begin
          s_d.phase = acr_pkg::ACR_RUN;
          s_d.data_ready_n_n = 1'b1;
        end
      end
      acr_pkg::ACR_HOLD: begin
        s_d.data_ready_n_n = 1'b0;
        s_d.cnt = 24'h000000;
        if (s_q.pin_s[1]) begin
          s_d.phase = acr_pkg::ACR_ACQ;
        end
      end
      acr_pkg::ACR_ACQ: begin
        s_d.data_ready_n_n = 1'b0;
        s_d.cnt = 24'(s_q.cnt + 24'h000001);
        if (s_q.cnt == 24'(acr_pkg::ACQUIRE_CYCLES - 1)) begin
          s_d.phase = acr_pkg::ACR_RUN;
          s_d.data_ready_n_n = 1'b1;
        end
      end
      acr_pkg::ACR_RUN: s_d.cnt = 24'h000000;
      default: s_d.phase = acr_pkg::ACR_POR;
    endcase
    if (soft_rst) begin
      for (int i = 0; i < acr_pkg::MAP_REGS; i++) begin
        s_d.regs[i] = 16'h0000;
      end
      s_d.regs[idx(acr_pkg::A_GAIN0_HI)] = acr_pkg::GAIN_RST[23:8];
      s_d.regs[idx(acr_pkg::A_GAIN0_LO)] = {acr_pkg::GAIN_RST[7:0], 8'h00};
      s_d.regs[idx(acr_pkg::A_GAIN1_HI)] = acr_pkg::GAIN_RST[23:8];
      s_d.regs[idx(acr_pkg::A_GAIN1_LO)] = {acr_pkg::GAIN_RST[7:0], 8'h00};
      // offsets back to no correction
      s_d.regs[idx(acr_pkg::A_OFF0_HI)] = acr_pkg::OFFSET_RST[23:8];
      s_d.regs[idx(acr_pkg::A_OFF0_LO)] = {acr_pkg::OFFSET_RST[7:0], 8'h00};
      s_d.regs[idx(acr_pkg::A_OFF1_HI)] = acr_pkg::OFFSET_RST[23:8];
      s_d.regs[idx(acr_pkg::A_OFF1_LO)] = {acr_pkg::OFFSET_RST[7:0], 8'h00};
      s_d.check_err = 1'b0;
      s_d.map_chg = 1'b0;
      s_d.map_val = 16'h0000;
      s_d.map_crc = acr_pkg::CRC_SEED;
      s_d.map_idx = 9'h000;
      s_d.in_frame = 1'b0;
      s_d.ack = 1'b0;
      s_d.ch0 = 24'h000000;
      s_d.ch1 = 24'h000000;
      s_d.miso = 1'b0;
      s_d.data_ready_n_n = 1'b0;
      s_d.cnt = 24'h000000;
      s_d.phase = s_q.pin_s[1] ? acr_pkg::ACR_ACQ : acr_pkg::ACR_HOLD;
    end
  end

  // state register; power-on loads all defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.phase <= acr_pkg::ACR_POR;
      s_q.sclk_s <= 3'h0;
      s_q.cs_s <= 3'h7;
      s_q.pin_s <= 2'h3;
      s_q.map_crc <= acr_pkg::CRC_SEED;
      s_q.regs[5'h03] <= acr_pkg::GAIN_RST[23:8];
      s_q.regs[5'h04] <= {acr_pkg::GAIN_RST[7:0], 8'h00};
      s_q.regs[5'h07] <= acr_pkg::GAIN_RST[23:8];
      s_q.regs[5'h08] <= {acr_pkg::GAIN_RST[7:0], 8'h00};
      // coefficients start at no offset
      s_q.regs[5'h01] <= acr_pkg::OFFSET_RST[23:8];
      s_q.regs[5'h02] <= {acr_pkg::OFFSET_RST[7:0], 8'h00};
      s_q.regs[5'h05] <= acr_pkg::OFFSET_RST[23:8];
      s_q.regs[5'h06] <= {acr_pkg::OFFSET_RST[7:0], 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign miso = s_q.miso;
  assign data_ready_n = s_q.data_ready_n_n;
endmodule

/* File: src/acr_pkg.sv */
// constants and types for the calibration, check-word and reset block
package acr_pkg;
  localparam longint unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned FRAME_WORDS = 4;
  localparam logic [6:0] FRAME_BITS = 7'h60;
  localparam logic [6:0] PAYLOAD_BITS = 7'h48;
  localparam logic [6:0] CHECK_END = 7'h58;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_ANSI = 16'h8005;
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h800000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [2:0] CMD_WRITE_TOP = 3'h3;
  localparam logic [2:0] ACK_WRITE_TOP = 3'h2;
  // register port addresses
  localparam logic [5:0] A_STATUS = 6'h01;
  localparam logic [5:0] A_MODE = 6'h02;
  localparam logic [5:0] A_OFF0_HI = 6'h03;
  localparam logic [5:0] A_OFF0_LO = 6'h04;
  localparam logic [5:0] A_GAIN0_HI = 6'h05;
  localparam logic [5:0] A_GAIN0_LO = 6'h06;
  localparam logic [5:0] A_OFF1_HI = 6'h07;
  localparam logic [5:0] A_OFF1_LO = 6'h08;
  localparam logic [5:0] A_GAIN1_HI = 6'h09;
  localparam logic [5:0] A_GAIN1_LO = 6'h0A;
  localparam logic [5:0] A_MAP_FIRST = 6'h02;
  localparam logic [5:0] A_MAP_LAST = 6'h12;
  localparam logic [5:0] A_MAP_CHECK = 6'h13;
  localparam int unsigned MAP_REGS = 17;
  localparam logic [8:0] MAP_LAST_BIT = 9'h10F;
  // field positions
  localparam int unsigned MODE_RX_CHECK = 0;
  localparam int unsigned MODE_ANSI = 1;
  localparam int unsigned MODE_MAP_CHECK = 2;
  localparam int unsigned STAT_CHECK_ERR = 13;
  localparam int unsigned STAT_MAP_CHG = 12;
  // times in ns and their cycle counts (least times round up)
  localparam longint unsigned POWER_ON_NS = 250_000;
  localparam longint unsigned RESET_LOW_MIN_NS = 2_000;
  localparam longint unsigned ACQUIRE_NS = 5_000;
  localparam int unsigned POWER_ON_CYCLES =
    int'((POWER_ON_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);
  localparam int unsigned RESET_LOW_CYCLES =
    int'((RESET_LOW_MIN_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);
  localparam int unsigned ACQUIRE_CYCLES =
    int'((ACQUIRE_NS * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);
  typedef enum logic [1:0] {
    ACR_POR = 2'b00,
    ACR_HOLD = 2'b01,
    ACR_ACQ = 2'b10,
    ACR_RUN = 2'b11
  } acr_phase_e;
endpackage

/* File: sim/acr_core_monitor.sv */
// port-level assertions for the calibration, check-word and reset block
module acr_monitor #(
  parameter int unsigned POR_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sync_reset_n,
  input wire logic raw_valid,
  input wire logic [23:0] raw_ch0,
  input wire logic [23:0] raw_ch1,
  input wire logic data_ready_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] por_cnt_q;
  logic por_wait_q;
  logic [7:0] low_cnt_q;
  logic [63:0] wr_seen_q;
  // power-on wait length, pin-low length, registers already written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_q <= 16'h0000;
      por_wait_q <= 1'b1;
      low_cnt_q <= 8'h00;
      wr_seen_q <= '0;
    end else begin
      if (por_wait_q) por_cnt_q <= por_cnt_q + 16'h0001;
      if (data_ready_n) por_wait_q <= 1'b0;
      if (sync_reset_n) low_cnt_q <= 8'h00;
      else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
      if (reg_wr) wr_seen_q[reg_addr] <= 1'b1;
    end
  end
  a_por_hold_low: assert property (
    $rose(rst_b) |-> !data_ready_n [*8])
    else $error("ready rose too soon after power-on");
  a_por_ready_time: assert property (
    $rose(data_ready_n) && por_wait_q |->
    por_cnt_q >= POR_CYCLES - 1 && por_cnt_q <= POR_CYCLES + 2)
    else $error("ready rose at wrong power-on count");
  a_pin_reset_hold: assert property (
    low_cnt_q > acr_pkg::RESET_LOW_CYCLES + 8 |-> !data_ready_n)
    else $error("ready high while reset pin held low");
  a_pin_reset_acq: assert property (
    $rose(sync_reset_n) && low_cnt_q > acr_pkg::RESET_LOW_CYCLES + 8
    |-> !data_ready_n [*8])
    else $error("ready rose right at reset pin release");
  a_cfg_defaults: assert property (
    reg_rd && !wr_seen_q[reg_addr] && reg_addr >= acr_pkg::A_MODE &&
    reg_addr <= acr_pkg::A_GAIN1_LO |=> reg_rdata ==
    (($past(reg_addr) == acr_pkg::A_GAIN0_HI ||
    $past(reg_addr) == acr_pkg::A_GAIN1_HI) ? 16'h8000 : 16'h0000))
    else $error("unwritten register lost its default");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr == 6'h00 || reg_addr > acr_pkg::A_MAP_CHECK)
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read gave nonzero data");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_miso_idle: assert property (cs_n [*8] |-> !miso)
    else $error("serial out active outside a frame");
endmodule

bind acr_core acr_monitor #(.POR_CYCLES(POR_CYCLES)) acr_monitor_inst (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk),
  .cs_n(cs_n), .mosi(mosi), .miso(miso), .sync_reset_n(sync_reset_n),
  .raw_valid(raw_valid), .raw_ch0(raw_ch0), .raw_ch1(raw_ch1),
  .data_ready_n(data_ready_n));

/* File: sim/acr_spi_host.sv */
// serial host model: four-word frames with check words
module acr_spi_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // link idles with clock low and frame deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // check word, msb first from an all-ones start
  function automatic logic [15:0] crc(input logic [271:0] d, input int n,
                                      input logic ansi);
    logic [15:0] c;
    logic [15:0] p;
    c = acr_pkg::CRC_SEED;
    p = ansi ? acr_pkg::POLY_ANSI : acr_pkg::POLY_CCITT;
    for (int i = 271; i > 271 - n; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? p : 16'h0000);
    return c;
  endfunction
  // one frame of n bits; bad flips the last bit of the sent check word
  task automatic frame(input logic [71:0] tx, input logic bad, input int n,
                       input logic ansi, output logic [95:0] rx);
    logic [95:0] d;
    d = {tx, crc({tx, 200'h0}, 72, ansi) ^ {15'h0, bad}, 8'h00};
    rx = '0;
    #5; // link edges stay clear of the block's clock edges
    cs_n = 1'b0;
    #200;
    for (int i = 95; i > 95 - n; i--) begin
      sclk = 1'b1;
      mosi = d[i];
      #80;
      sclk = 1'b0;
      rx[i] = miso;
      #80;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #395;
  endtask
endmodule

/* File: sim/acr_core_tb.sv */
// self-checking bench for the calibration, check-word and reset block
module acr_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned POR = 50;
  localparam logic [127:0] CV = 128'h0000_1000_4000_0000_FFFF_F000_FFFF_FF00;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sync_reset_n = 1'b1;
  logic raw_valid = 1'b0;
  logic [23:0] raw_ch0 = 24'h000000;
  logic [23:0] raw_ch1 = 24'h000000;
  logic [15:0] reg_rdata, rv;
  logic sclk, cs_n, mosi, miso, data_ready_n;
  logic [15:0] shadow [0:18];
  logic [95:0] rx;
  int error_cnt = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  acr_core #(.POR_CYCLES(POR)) acr_core_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .sync_reset_n(sync_reset_n),
    .raw_valid(raw_valid), .raw_ch0(raw_ch0), .raw_ch1(raw_ch1),
    .data_ready_n(data_ready_n));
  acr_spi_host acr_spi_host_inst (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // compare and count
  task automatic chk(input logic [23:0] s, input logic [23:0] e,
                     input string nm);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // register port write and read
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    shadow[a] = d;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rv = reg_rdata;
    if (nm != "") chk({8'h00, rv}, {8'h00, e}, nm);
  endtask
  // full frame, then its output check word
  task automatic fr(input logic [71:0] tx, input logic bad);
    logic a;
    a = shadow[2][1];
    acr_spi_host_inst.frame(tx, bad, 96, a, rx);
    chk({8'h00, rx[23:8]}, {8'h00, acr_spi_host_inst.crc(
      {rx[95:24], 200'h0}, 72, a)}, "out_check");
  endtask
  // bounded wait for the port-ready rise
  task automatic wait_rdy();
    for (int n = 0; n < 2000 && data_ready_n !== 1'b1; n++) @(posedge clk);
    chk({23'h0, data_ready_n}, 24'h1, "data_ready_n");
  endtask
  // all mapped registers against their defaults
  task automatic defaults_chk();
    for (int a = 2; a <= 18; a++)
      shadow[a] = (a == 5 || a == 9) ? 16'h8000 : 16'h0000;
    for (int a = 2; a <= 18; a++)
      rd(6'(a), shadow[a], "default");
  endtask
  // expected corrected result with full-scale clamp
  function automatic logic [23:0] corr(input logic [23:0] r,
                                       input logic [23:0] o,
                                       input logic [23:0] g);
    logic signed [49:0] p;
    p = (($signed({{2{r[23]}}, r}) - $signed({{2{o[23]}}, o})) *
      $signed({1'b0, g})) >>> 23;
    if (p > 50'sd8388607) return 24'h7FFFFF;
    if (p < -50'sd8388608) return 24'h800000;
    return p[23:0];
  endfunction
  function automatic logic [15:0] mapcrc();
    logic [271:0] d;
    for (int a = 2; a <= 18; a++) d[271 - 16 * (a - 2) -: 16] = shadow[a];
    return acr_spi_host_inst.crc(d, 272, shadow[2][1]);
  endfunction
  task automatic results();
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #1_500_000;
    error_cnt++;
    results();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    wait_rdy();
    defaults_chk();
    rd(6'h1F, 16'h0000, "unmapped");
    for (int i = 0; i < 8; i++) wr(6'h03 + 6'(i), CV[127 - 16 * i -: 16]);
    for (int p = 0; p < 2; p++) begin
      wr(acr_pkg::A_MODE, {14'h0, p[0], 1'b0});
      @(posedge clk);
      raw_ch0 <= 24'h000110;
      raw_ch1 <= 24'h7FFFF0;
      raw_valid <= 1'b1;
      @(posedge clk);
      raw_valid <= 1'b0;
      repeat (5) @(posedge clk);
      fr(72'h0, 1'b0);
      chk(rx[71:48], corr(24'h000110, 24'h000010, 24'h400000), "ch0");
      chk(rx[47:24], corr(24'h7FFFF0, 24'hFFFFF0, 24'hFFFFFF), "ch1");
    end
    // input check: blocked reset, forced write, status reply
    wr(acr_pkg::A_MODE, 16'h0001);
    fr({acr_pkg::CMD_RESET, 56'h0}, 1'b1);
    fr(72'h0, 1'b0);
    chk({23'h0, rx[80 + acr_pkg::STAT_CHECK_ERR]}, 24'h1, "check_err");
    fr({3'h3, 6'h0B, 15'h0, 16'h1234, 32'h0}, 1'b1);
    shadow[11] = 16'h1234;
    fr(72'h0, 1'b0);
    chk({23'h0, rx[80 + acr_pkg::STAT_CHECK_ERR]}, 24'h1, "check_err");
    fr(72'h0, 1'b0);
    chk({23'h0, rx[80 + acr_pkg::STAT_CHECK_ERR]}, 24'h0, "check_err");
    rd(6'h0B, 16'h1234, "spare");
    rd(acr_pkg::A_GAIN0_HI, 16'h4000, "gain0");
    // accepted write answers with its acknowledge word, not status
    fr({3'h3, 6'h0B, 15'h0, 16'h5678, 32'h0}, 1'b0);
    shadow[11] = 16'h5678;
    fr(72'h0, 1'b0);
    rv = {acr_pkg::ACK_WRITE_TOP, 13'h0580};
    chk({8'h00, rx[95:80]}, {8'h00, rv}, "write_ack");
    rd(6'h0B, 16'h5678, "spare");
    // register map check value and change flag
    wr(acr_pkg::A_MODE, 16'h0004);
    repeat (700) @(posedge clk);
    rd(acr_pkg::A_STATUS, 16'h0000, "");
    rd(acr_pkg::A_MAP_CHECK, mapcrc(), "map_value");
    repeat (700) @(posedge clk);
    rd(acr_pkg::A_STATUS, 16'h0000, "");
    chk({23'h0, rv[acr_pkg::STAT_MAP_CHG]}, 24'h0, "map_chg");
    wr(6'h0C, 16'h00FF);
    repeat (700) @(posedge clk);
    rd(acr_pkg::A_STATUS, 16'h0000, "");
    chk({23'h0, rv[acr_pkg::STAT_MAP_CHG]}, 24'h1, "map_chg");
    rd(acr_pkg::A_STATUS, 16'h0000, "");
    chk({23'h0, rv[acr_pkg::STAT_MAP_CHG]}, 24'h0, "map_chg");
    rd(acr_pkg::A_MAP_CHECK, mapcrc(), "map_value");
    // reset command: cut short, then whole, then early traffic
    acr_spi_host_inst.frame({acr_pkg::CMD_RESET, 56'h0}, 1'b0, 50, 1'b0, rx);
    rd(acr_pkg::A_GAIN0_HI, 16'h4000, "gain0");
    fr({acr_pkg::CMD_RESET, 56'h0}, 1'b0);
    chk({23'h0, data_ready_n}, 24'h0, "data_ready_n");
    acr_spi_host_inst.frame({3'h3, 6'h0D, 15'h0, 16'hBEEF, 32'h0},
      1'b0, 96, 1'b0, rx);
    wait_rdy();
    defaults_chk();
    // reset pin: short pulse ignored, long pulse resets
    wr(acr_pkg::A_GAIN0_HI, 16'h1111);
    sync_reset_n <= 1'b0;
    repeat (50) @(posedge clk);
    sync_reset_n <= 1'b1;
    repeat (300) @(posedge clk);
    rd(acr_pkg::A_GAIN0_HI, 16'h1111, "gain0");
    sync_reset_n <= 1'b0;
    repeat (150) @(posedge clk);
    chk({23'h0, data_ready_n}, 24'h0, "data_ready_n");
    sync_reset_n <= 1'b1;
    wait_rdy();
    defaults_chk();
    results();
  end
endmodule
